// [ptm_pkg.sv]
// How it works
// RL1: An 11-bit prescaler runs on the system clock and is cleared by reset.
// RL2: The prescaler holds still during reset and while stop mode is asserted.
// RL3: Each timer's input tick is a prescaler tap chosen by its mode register.
// RL4: The interval timer is an 8-bit up counter, tap chosen by its mode.
// RL5: The interval timer wraps from FF to 00, overflowing every 256 ticks.
// RL6: Interval timer overflow sets its flag, bit 2 of its flag nibble.
// RL7: The multifunction timer counts up one per tick from its loaded value.
// RL8: Its overflow from FF reloads the load value, or 00 when free-running.
// RL9: Its overflow sets its flag at bit 2; only software or reset clears it.
// RL10: With the watchdog flag set, an overflow pulses the MCU reset request.
// RL11: Output modes 1 to 4 hand the shared pin to the timer; reset drives it low.
// RL12: Toggle mode inverts the output on each tick taken while at FF.
// RL13: Force-low mode drives the output low at overflow; use when high.
// RL14: Force-high mode drives the output high at overflow; use when low.
// RL15: PWM mode derives pulse period and duty from counting mode and load.
// RL16: The 4-bit counting mode picks reload or free-run and the tap; reset 0.
// RL17: A counting-mode write takes effect a fixed latency after it is made.
// RL18: The output mode register is 3 bits, read and write, reset to 0.
// RL19: The lower load nibble resets to 0; the upper has no defined reset.
// RL20: A low write only stores; a high write stores and loads the counter.
// RL21: Reading the high count nibble latches the low nibble for a later read.
// RL22: Tap and PWM encodings are this block's own and are documented.
// RL23: Flags set in the overflow cycle; a set beats a simultaneous clear.
package ptm_pkg;
  localparam int ADDR_W = 10;
  localparam int PSC_W = 11;
  localparam int CNT_W = 8;
  localparam logic [ADDR_W-1:0] OFS_IT_FLAG = 10'h001;
  localparam logic [ADDR_W-1:0] OFS_MT_FLAG = 10'h002;
  localparam logic [ADDR_W-1:0] OFS_IT_MODE = 10'h008;
  localparam logic [ADDR_W-1:0] OFS_MT_CMODE = 10'h00D;
  localparam logic [ADDR_W-1:0] OFS_MT_LOW = 10'h00E;
  localparam logic [ADDR_W-1:0] OFS_MT_HIGH = 10'h00F;
  localparam logic [ADDR_W-1:0] OFS_MT_OMODE = 10'h014;
  localparam logic [ADDR_W-1:0] OFS_WDOG = 10'h020;
  localparam int BIT_IRQ = 2;
  localparam int BIT_WDOG = 1;
  localparam int BIT_RELOAD = 3;
  localparam logic [PSC_W-1:0] PSC_RST = 11'h000;
  localparam logic [CNT_W-1:0] CNT_RST = 8'h00;
  localparam logic [CNT_W-1:0] CNT_TOP = 8'hFF;
  localparam logic [3:0] NIB_RST = 4'h0;
  localparam logic [2:0] OM_PORT = 3'h0;
  localparam logic [2:0] OM_TOGGLE = 3'h1;
  localparam logic [2:0] OM_LOW = 3'h2;
  localparam logic [2:0] OM_HIGH = 3'h3;
  localparam logic [2:0] OM_PWM = 3'h4;
  localparam int MODE_LAT_NS = 20;
  localparam int CLK_NS = 10;
  localparam int MODE_LAT_CYC = (MODE_LAT_NS + CLK_NS - 1) / CLK_NS;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [3:0] wdata;
  } ptm_req_t;
endpackage

// [ptm_timers.sv]
`timescale 1ns/1ps
`default_nettype none
module ptm_timers #(
  parameter int MODE_LAT = ptm_pkg::MODE_LAT_CYC
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Core control.
  input wire logic stop_i,
  // Register access from the core.
  input wire ptm_pkg::ptm_req_t req_i,
  output logic [3:0] rdata_o,
  // Events and pin.
  output logic wdt_reset_o,
  output logic pin_out_o,
  output logic pin_oe_o
);
  import ptm_pkg::*;

  if (MODE_LAT < 1 || MODE_LAT > 15) begin
    $error("MODE_LAT must lie between 1 and 15.");
  end

  // ==========================================================
  // Tap selection
  // ==========================================================
  // Select code n picks a divide by 2^k, k in {1,2,3,5,7,9,10,11}.
  function automatic logic tap_tick(input logic [PSC_W-1:0] psc,
                                    input logic [2:0] sel);
    logic [PSC_W-1:0] mask;
    mask = '0;
    case (sel)
      3'h0: mask = 11'h001;
      3'h1: mask = 11'h003;
      3'h2: mask = 11'h007;
      3'h3: mask = 11'h01F;
      3'h4: mask = 11'h07F;
      3'h5: mask = 11'h1FF;
      3'h6: mask = 11'h3FF;
      default: mask = 11'h7FF;
    endcase
    return (psc & mask) == mask;
  endfunction

  // ==========================================================
  // Prescaler
  // ==========================================================
  logic [PSC_W-1:0] psc;
  logic psc_run;

  assign psc_run = !stop_i;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      psc <= PSC_RST; // RL1
    end else if (psc_run) begin // RL2
      psc <= psc + 11'h001; // RL1
    end
  end

  // ==========================================================
  // Register decode
  // ==========================================================
  // Which register an address selects; shared by writes and reads.
  typedef enum logic [3:0] {
    PTM_SEL_NONE,
    PTM_SEL_IT_FLAG,
    PTM_SEL_MT_FLAG,
    PTM_SEL_IT_MODE,
    PTM_SEL_CMODE,
    PTM_SEL_LOW,
    PTM_SEL_HIGH,
    PTM_SEL_OMODE,
    PTM_SEL_WDOG
  } ptm_sel_t;

  function automatic ptm_sel_t addr_decode(input logic [ADDR_W-1:0] addr);
    ptm_sel_t sel;
    sel = PTM_SEL_NONE;
    if (addr == OFS_IT_FLAG) begin
      sel = PTM_SEL_IT_FLAG;
    end else if (addr == OFS_MT_FLAG) begin
      sel = PTM_SEL_MT_FLAG;
    end else if (addr == OFS_IT_MODE) begin
      sel = PTM_SEL_IT_MODE;
    end else if (addr == OFS_MT_CMODE) begin
      sel = PTM_SEL_CMODE;
    end else if (addr == OFS_MT_LOW) begin
      sel = PTM_SEL_LOW;
    end else if (addr == OFS_MT_HIGH) begin
      sel = PTM_SEL_HIGH;
    end else if (addr == OFS_MT_OMODE) begin
      sel = PTM_SEL_OMODE;
    end else if (addr == OFS_WDOG) begin
      sel = PTM_SEL_WDOG;
    end
    return sel;
  endfunction

  ptm_sel_t req_sel;

  assign req_sel = addr_decode(req_i.addr);

  logic wr_it_flag, wr_mt_flag, wr_it_mode, wr_cmode;
  logic wr_low, wr_high, wr_omode, wr_wdog, rd_high;

  always_comb begin
    wr_it_flag = 1'b0;
    wr_mt_flag = 1'b0;
    wr_it_mode = 1'b0;
    wr_cmode = 1'b0;
    wr_low = 1'b0;
    wr_high = 1'b0;
    wr_omode = 1'b0;
    wr_wdog = 1'b0;
    if (req_sel == PTM_SEL_IT_FLAG) begin
      wr_it_flag = req_i.wr;
    end else if (req_sel == PTM_SEL_MT_FLAG) begin
      wr_mt_flag = req_i.wr;
    end else if (req_sel == PTM_SEL_IT_MODE) begin
      wr_it_mode = req_i.wr;
    end else if (req_sel == PTM_SEL_CMODE) begin
      wr_cmode = req_i.wr;
    end else if (req_sel == PTM_SEL_LOW) begin
      wr_low = req_i.wr;
    end else if (req_sel == PTM_SEL_HIGH) begin
      wr_high = req_i.wr;
    end else if (req_sel == PTM_SEL_OMODE) begin
      wr_omode = req_i.wr;
    end else if (req_sel == PTM_SEL_WDOG) begin
      wr_wdog = req_i.wr;
    end
  end

  assign rd_high = req_i.rd && (req_sel == PTM_SEL_HIGH);

  // ==========================================================
  // Mode registers
  // ==========================================================
  logic [3:0] it_mode;
  logic [3:0] cmode;
  logic [3:0] cmode_pend;
  logic [3:0] cmode_wait;
  logic [2:0] omode;
  logic wdog_en;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      it_mode <= NIB_RST;
    end else if (wr_it_mode) begin
      it_mode <= req_i.wdata;
    end
  end

  // A counting-mode write is held and applied after the latency.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmode <= NIB_RST; // RL16
      cmode_pend <= NIB_RST;
      cmode_wait <= 4'h0;
    end else if (wr_cmode) begin
      cmode_pend <= req_i.wdata;
      cmode_wait <= 4'(MODE_LAT); // RL17
    end else if (cmode_wait == 4'h1) begin
      cmode <= cmode_pend; // RL17
      cmode_wait <= 4'h0;
    end else if (cmode_wait != 4'h0) begin
      cmode_wait <= cmode_wait - 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      omode <= OM_PORT; // RL18
    end else if (wr_omode) begin
      omode <= req_i.wdata[2:0]; // RL18
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdog_en <= 1'b0;
    end else if (wr_wdog) begin
      wdog_en <= req_i.wdata[BIT_WDOG];
    end
  end

  // ==========================================================
  // Interval timer
  // ==========================================================
  logic it_tick, it_ovf;
  logic [CNT_W-1:0] it_cnt;
  logic it_flag;

  assign it_tick = psc_run && tap_tick(psc, it_mode[2:0]); // RL3
  assign it_ovf = it_tick && (it_cnt == CNT_TOP);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      it_cnt <= CNT_RST; // RL4
    end else if (it_tick) begin
      it_cnt <= it_cnt + 8'h01; // RL5
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      it_flag <= 1'b0;
    end else if (it_ovf) begin
      it_flag <= 1'b1; // RL6 RL23
    end else if (wr_it_flag && !req_i.wdata[BIT_IRQ]) begin
      it_flag <= 1'b0;
    end
  end

  // ==========================================================
  // Multifunction timer
  // ==========================================================
  logic mt_tick, mt_ovf;
  logic [CNT_W-1:0] mt_cnt;
  logic [3:0] load_lo, load_hi, cnt_lo_latch;
  logic [CNT_W-1:0] load_val;
  logic mt_flag;

  assign mt_tick = psc_run && tap_tick(psc, cmode[2:0]); // RL3
  assign mt_ovf = mt_tick && (mt_cnt == CNT_TOP);
  assign load_val = {load_hi, load_lo};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      load_lo <= NIB_RST; // RL19
    end else if (wr_low) begin
      load_lo <= req_i.wdata; // RL20
    end
  end

  // Upper load nibble is undefined after reset, so it has no reset.
  always_ff @(posedge clk_i) begin
    if (wr_high) begin
      load_hi <= req_i.wdata; // RL19
    end
  end

  // A software load wins over a tick in the same cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mt_cnt <= CNT_RST;
    end else if (wr_high) begin
      mt_cnt <= {req_i.wdata, load_lo}; // RL20
    end else if (mt_ovf) begin
      mt_cnt <= cmode[BIT_RELOAD] ? load_val : CNT_RST; // RL8
    end else if (mt_tick) begin
      mt_cnt <= mt_cnt + 8'h01; // RL7
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mt_flag <= 1'b0;
    end else if (mt_ovf) begin
      mt_flag <= 1'b1; // RL9 RL23
    end else if (wr_mt_flag && !req_i.wdata[BIT_IRQ]) begin
      mt_flag <= 1'b0; // RL9
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_reset_o <= 1'b0;
    end else begin
      wdt_reset_o <= mt_ovf && wdog_en; // RL10
    end
  end

  // ==========================================================
  // Timer output
  // ==========================================================
  // PWM: free-run is high while count < load value (duty load/256);
  // reload is high during the final count FF of each period.
  logic next_pin;

  always_comb begin
    next_pin = pin_out_o;
    case (omode)
      OM_TOGGLE: begin
        if (mt_ovf) begin
          next_pin = !pin_out_o; // RL12
        end
      end
      OM_LOW: begin
        if (mt_ovf) begin
          next_pin = 1'b0; // RL13
        end
      end
      OM_HIGH: begin
        if (mt_ovf) begin
          next_pin = 1'b1; // RL14
        end
      end
      OM_PWM: begin
        if (cmode[BIT_RELOAD]) begin
          next_pin = (mt_cnt == CNT_TOP); // RL15 RL22
        end else begin
          next_pin = (mt_cnt < load_val); // RL15 RL22
        end
      end
      default: begin
        next_pin = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_out_o <= 1'b0; // RL11
      pin_oe_o <= 1'b0;
    end else begin
      pin_out_o <= next_pin;
      pin_oe_o <= (omode == OM_TOGGLE) || (omode == OM_LOW) ||
                  (omode == OM_HIGH) || (omode == OM_PWM); // RL11
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_lo_latch <= NIB_RST;
    end else if (rd_high) begin
      cnt_lo_latch <= mt_cnt[3:0]; // RL21
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 4'h0;
    end else if (!req_i.rd) begin
      rdata_o <= 4'h0;
    end else if (req_sel == PTM_SEL_IT_FLAG) begin
      rdata_o <= {1'b0, it_flag, 2'b00};
    end else if (req_sel == PTM_SEL_MT_FLAG) begin
      rdata_o <= {1'b0, mt_flag, 2'b00};
    end else if (req_sel == PTM_SEL_LOW) begin
      rdata_o <= cnt_lo_latch; // RL21
    end else if (req_sel == PTM_SEL_HIGH) begin
      rdata_o <= mt_cnt[7:4]; // RL21
    end else if (req_sel == PTM_SEL_OMODE) begin
      rdata_o <= {1'b0, omode};
    end else if (req_sel == PTM_SEL_WDOG) begin
      rdata_o <= {2'b00, wdog_en, 1'b0};
    end else begin
      rdata_o <= 4'h0;
    end
  end
endmodule
`default_nettype wire

// [ptm_timers_props.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks for the prescaler and timers.
module ptm_timers_props (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Core side.
  input wire logic stop_i,
  input wire ptm_pkg::ptm_req_t req_i,
  input wire logic [3:0] rdata_o,
  // Events and pin.
  input wire logic wdt_reset_o,
  input wire logic pin_out_o,
  input wire logic pin_oe_o
);
  import ptm_pkg::*;
  logic om_wr;
  assign om_wr = req_i.wr && (req_i.addr == OFS_MT_OMODE);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  rst_low_a:
    assert property ($fell(rst_i) |-> rdata_o == 4'h0 && !wdt_reset_o
      && !pin_out_o && !pin_oe_o) else $error("outputs not idle at reset");
  rd_idle_a:
    assert property (!$past(req_i.rd) |-> rdata_o == 4'h0)
      else $error("read data without a read");
  unmapped_a:
    assert property (req_i.rd && req_i.addr > OFS_WDOG |=> rdata_o == 4'h0)
      else $error("unmapped read not zero");
  omode_w3_a:
    assert property (req_i.rd && req_i.addr == OFS_MT_OMODE |=> !rdata_o[3])
      else $error("output mode wider than 3 bits");
  oe_follow_a:
    assert property (om_wr |=> ##1 pin_oe_o ==
      ($past(req_i.wdata[2:0], 2) inside {[3'h1:3'h4]}))
      else $error("pin enable does not follow output mode");
  oe_cause_a:
    assert property ($rose(pin_oe_o) |-> $past(om_wr) || $past(om_wr, 2))
      else $error("pin enable rose without a mode write");
  wdt_pulse_a:
    assert property (wdt_reset_o |=> !wdt_reset_o)
      else $error("reset request longer than one cycle");
  stop_hold_a:
    assert property ((stop_i && !req_i.wr) [*4] |-> $stable(pin_out_o)
      && !wdt_reset_o) else $error("activity while stopped");
endmodule
`default_nettype wire

// [ptm_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Core model issuing one register access at a time.
module ptm_core_model (
  // Clock.
  input wire logic clk_i,
  // Register access.
  output var ptm_pkg::ptm_req_t req_o,
  input wire logic [3:0] rdata_i
);
  import ptm_pkg::*;
  initial req_o = '0;
  // Idle address and data are inverted so stale values never look valid.
  task automatic xfer(input logic [9:0] a, input logic w,
                      input logic [3:0] d, output logic [3:0] q);
    @(posedge clk_i);
    #1;
    req_o = '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clk_i);
    #1;
    q = rdata_i;
    req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
endmodule
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Register level tests of the prescaler and timers.
module tb;
  import ptm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic stop_i = 1'b0;
  ptm_req_t req;
  logic [3:0] rdata;
  logic [3:0] q;
  logic wdt;
  logic pout;
  logic poe;
  int num_errors = 0;
  int checks = 0;
  int wdt_n = 0;
  ptm_timers dut_u (.clk_i(clk_i), .rst_i(rst_i), .stop_i(stop_i),
    .req_i(req), .rdata_o(rdata), .wdt_reset_o(wdt), .pin_out_o(pout),
    .pin_oe_o(poe));
  ptm_core_model core_u (.clk_i(clk_i), .req_o(req), .rdata_i(rdata));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (wdt === 1'b1) begin
      wdt_n++;
    end
  end
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [3:0] d);
    core_u.xfer(a, 1'b1, d, q);
  endtask
  task automatic rd(input logic [9:0] a, input logic [3:0] e);
    core_u.xfer(a, 1'b0, 4'h0, q);
    chk(q, e);
  endtask
  // Parks the counter at FF with F0 as load value, then lets one
  // overflow happen and freezes again.
  task automatic ovf;
    stop_i = 1'b1;
    wr(OFS_MT_FLAG, 4'h0);
    wr(OFS_MT_LOW, 4'hF);
    wr(OFS_MT_HIGH, 4'hF);
    wr(OFS_MT_LOW, 4'h0);
    rd(OFS_MT_HIGH, 4'hF);
    rd(OFS_MT_LOW, 4'hF);
    stop_i = 1'b0;
    repeat (6) @(posedge clk_i);
    #1;
    stop_i = 1'b1;
    rd(OFS_MT_FLAG, 4'h4);
  endtask
  task automatic results;
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #50000;
    num_errors++;
    results();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    rd(OFS_MT_OMODE, 4'h0);
    rd(10'h3FF, 4'h0);
    chk({2'b0, poe, pout}, 4'h0);
    wr(OFS_IT_MODE, 4'h0);
    wr(OFS_IT_FLAG, 4'h0);
    rd(OFS_IT_FLAG, 4'h0);
    repeat (520) @(posedge clk_i);
    #1;
    rd(OFS_IT_FLAG, 4'h4);
    wr(OFS_IT_FLAG, 4'h0);
    rd(OFS_IT_FLAG, 4'h0);
    wr(OFS_MT_OMODE, {1'b0, OM_TOGGLE});
    rd(OFS_MT_OMODE, {1'b0, OM_TOGGLE});
    ovf();
    chk({2'b0, poe, pout}, 4'h3);
    wr(OFS_MT_OMODE, {1'b0, OM_LOW});
    ovf();
    chk({3'b0, pout}, 4'h0);
    wr(OFS_MT_OMODE, {1'b0, OM_HIGH});
    ovf();
    chk({3'b0, pout}, 4'h1);
    wr(OFS_MT_CMODE, 4'h8);
    wr(OFS_MT_OMODE, {1'b0, OM_PWM});
    ovf();
    rd(OFS_MT_HIGH, 4'hF);
    chk({3'b0, pout}, 4'h0);
    wr(OFS_MT_CMODE, 4'h0);
    ovf();
    rd(OFS_MT_HIGH, 4'h0);
    chk({3'b0, pout}, 4'h1);
    chk(wdt_n[3:0], 4'h0);
    wr(OFS_WDOG, 4'h2);
    rd(OFS_WDOG, 4'h2);
    ovf();
    chk(wdt_n[3:0], 4'h1);
    wr(OFS_MT_OMODE, {1'b0, OM_PORT});
    rd(OFS_MT_OMODE, 4'h0);
    chk({2'b0, poe, pout}, 4'h0);
    // Divide-by-4 tap gives two ticks in eight running cycles, and the
    // low count read must return the nibble latched by the high read.
    wr(OFS_MT_CMODE, 4'h1);
    wr(OFS_MT_LOW, 4'hE);
    wr(OFS_MT_HIGH, 4'h2);
    rd(OFS_MT_HIGH, 4'h2);
    stop_i = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
    stop_i = 1'b1;
    rd(OFS_MT_LOW, 4'hE);
    rd(OFS_MT_HIGH, 4'h3);
    rd(OFS_MT_LOW, 4'h0);
    wr(OFS_MT_HIGH, 4'h5);
    rd(OFS_MT_HIGH, 4'h5);
    rd(OFS_MT_LOW, 4'hE);
    chk(wdt_n[3:0], 4'h1);
    results();
  end
endmodule
bind ptm_timers ptm_timers_props chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .stop_i(stop_i), .req_i(req_i), .rdata_o(rdata_o),
  .wdt_reset_o(wdt_reset_o), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o));
`default_nettype wire
